// *** verilog/sal_consts.vh ***
`ifndef SAL_CONSTS_VH
`define SAL_CONSTS_VH

// Datapath widths
`define SAL_W 16
`define SAL_NIB 4
`define SAL_NSLICE 4

// Register byte offsets, decoded on the low address byte
`define SAL_ADEC_HI 7
`define SAL_OFF_AOPER 8'h00
`define SAL_OFF_BOPER 8'h04
`define SAL_OFF_CTRL 8'h08
`define SAL_OFF_STAT 8'h0c
`define SAL_OFF_SELOUT 8'h10

// Control register fields
`define SAL_CTRL_FSEL_HI 3
`define SAL_CTRL_FSEL_LO 0
`define SAL_CTRL_MODE 4
`define SAL_CTRL_CIN 5
`define SAL_CTRL_AUXN 6
`define SAL_CTRL_SAVEDN 7
`define SAL_CTRL_RSEL 8
`define SAL_CTRL_W 9

// Status register fields
`define SAL_STAT_LOEQ 16
`define SAL_STAT_HIEQ 17
`define SAL_STAT_COUT 18

// Reset values: function select lines and active-low requests idle high
`define SAL_CTRL_RST 9'h0cf
`define SAL_WORD_RST 16'h0000
`define SAL_HTRANS_NONSEQ_BIT 1
`define SAL_HRESP_OKAY 1'b0

`endif

// *** verilog/sal_slice.v ***
`timescale 1ns/10ps
`default_nettype none
// One 4-bit function slice with group generate/propagate for look-ahead
module sal_slice (
	input wire [3:0] opA,
	input wire [3:0] opB,
	input wire [3:0] fsel,
	input wire modeLogic,
	input wire cin,
	output wire [3:0] f,
	output wire grpGen,
	output wire grpProp,
	output wire aEqB
);
	wire [3:0] t;
	wire [3:0] u;
	wire [3:0] g;
	wire [3:0] p;
	wire [3:0] c;

	// Operand terms: arithmetic result is t plus u plus carry
	assign t = opA | (opB & {4{fsel[0]}}) | (~opB & {4{fsel[1]}});
	assign u = (opA & ~opB & {4{fsel[2]}}) | (opA & opB & {4{fsel[3]}});
	assign g = t & u;
	assign p = t | u;

	// Internal carries inside the slice only; slices do not ripple to each other
	assign c[0] = cin;
	assign c[1] = g[0] | (p[0] & c[0]);
	assign c[2] = g[1] | (p[1] & c[1]);
	assign c[3] = g[2] | (p[2] & c[2]);

	// Logic mode drops carries from f; group generate and propagate still come out
	assign f = modeLogic ? ~(t ^ u) : (t ^ u ^ c[3:0]);
	assign grpGen = g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0]);
	assign grpProp = &p;

	// All ones in subtract mode means equal nibbles
	assign aEqB = &f;
endmodule // sal_slice
`default_nettype wire

// *** verilog/sal_top.v ***
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sal_consts.vh"
// 16-bit ALU datapath with AHB-Lite register access
module sal_top (
	input wire mclk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	input wire [15:0] busDataIn,
	output reg [15:0] aluResult,
	output reg [15:0] selectorOut,
	output reg lowByteEqual,
	output reg highByteEqual
);
	// Register file
	reg [15:0] aOperandLeg_reg;
	reg [15:0] aOperandLeg_next;
	reg [15:0] bOperandLeg_reg;
	reg [15:0] bOperandLeg_next;
	reg [8:0] ctrl_reg;
	reg [8:0] ctrl_next;
	reg carryOut_reg;
	// Bus pipeline
	reg wrPend_reg;
	reg [7:0] wrAddr_reg;
	// Pin synchroniser
	reg [15:0] busSync1_reg;
	reg [15:0] busSync2_reg;
	// Datapath
	wire [3:0] bufferedFunctionSelect;
	wire logicArithSelect;
	wire effectiveCarryIn;
	wire auxTerm;
	wire [15:0] aluOut;
	wire [3:0] sliceGen;
	wire [3:0] sliceProp;
	wire [3:0] sliceEq;
	wire [3:0] sliceCarry;
	wire groupCout;
	wire [15:0] selected;
	wire addrValid;
	wire [7:0] addrLow;
	reg [31:0] readMux;

	// Unselected bits of the address alias the map
	assign addrLow = haddr[`SAL_ADEC_HI:0];
	assign addrValid = hsel & htrans[`SAL_HTRANS_NONSEQ_BIT] & hready;

	// Active-low select lines inverted before the slices
	assign bufferedFunctionSelect = ~ctrl_reg[`SAL_CTRL_FSEL_HI:`SAL_CTRL_FSEL_LO];
	assign logicArithSelect = ctrl_reg[`SAL_CTRL_MODE];
	// NOR of two active-low requests: both asserted
	assign auxTerm = ~(ctrl_reg[`SAL_CTRL_AUXN] | ctrl_reg[`SAL_CTRL_SAVEDN]);
	assign effectiveCarryIn = ctrl_reg[`SAL_CTRL_CIN] ^ auxTerm;

	// Look-ahead carries from group terms, all from the same carry-in
	assign sliceCarry[0] = effectiveCarryIn;
	assign sliceCarry[1] = sliceGen[0] | (sliceProp[0] & effectiveCarryIn);
	assign sliceCarry[2] = sliceGen[1] | (sliceProp[1] & sliceGen[0])
		| (sliceProp[1] & sliceProp[0] & effectiveCarryIn);
	assign sliceCarry[3] = sliceGen[2] | (sliceProp[2] & sliceGen[1])
		| (sliceProp[2] & sliceProp[1] & sliceGen[0])
		| (sliceProp[2] & sliceProp[1] & sliceProp[0] & effectiveCarryIn);
	assign groupCout = sliceGen[3] | (sliceProp[3] & sliceCarry[3]);

	// Four slices, A leg first operand, B leg second
	genvar gi;
	generate
		for (gi = 0; gi < `SAL_NSLICE; gi = gi + 1) begin : gSlice
			sal_slice uSlice (
				.opA(aOperandLeg_reg[gi*`SAL_NIB +: `SAL_NIB]),
				.opB(bOperandLeg_reg[gi*`SAL_NIB +: `SAL_NIB]),
				.fsel(bufferedFunctionSelect),
				.modeLogic(logicArithSelect),
				.cin(sliceCarry[gi]),
				.f(aluOut[gi*`SAL_NIB +: `SAL_NIB]),
				.grpGen(sliceGen[gi]),
				.grpProp(sliceProp[gi]),
				.aEqB(sliceEq[gi])
			);
		end
	endgenerate

	// Result selector: ALU on input one, synchronised bus data on input two
	assign selected = ctrl_reg[`SAL_CTRL_RSEL] ? aluOut : busSync2_reg;

	// Register write, taken in the data phase of a captured write
	always @* begin
		aOperandLeg_next = aOperandLeg_reg;
		bOperandLeg_next = bOperandLeg_reg;
		ctrl_next = ctrl_reg;
		if (wrPend_reg) begin
			case (wrAddr_reg)
				`SAL_OFF_AOPER: aOperandLeg_next = hwdata[15:0];
				`SAL_OFF_BOPER: bOperandLeg_next = hwdata[15:0];
				`SAL_OFF_CTRL: ctrl_next = hwdata[`SAL_CTRL_W-1:0];
				default: ;
			endcase
		end
	end

	// Read mux uses next values so a write then read returns fresh data
	always @* begin
		readMux = 32'h00000000;
		case (addrLow)
			`SAL_OFF_AOPER: readMux = {16'h0000, aOperandLeg_next};
			`SAL_OFF_BOPER: readMux = {16'h0000, bOperandLeg_next};
			`SAL_OFF_CTRL: readMux = {23'h000000, ctrl_next};
			`SAL_OFF_STAT: readMux = {13'h0000, carryOut_reg, highByteEqual,
				lowByteEqual, aluResult};
			`SAL_OFF_SELOUT: readMux = {16'h0000, selectorOut};
			default: readMux = 32'h00000000;
		endcase
	end

	// Bus slave: zero wait states, always OKAY
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp <= `SAL_HRESP_OKAY;
			hrdata <= 32'h00000000;
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= `SAL_HRESP_OKAY;
			wrPend_reg <= addrValid & hwrite;
			if (addrValid) begin
				wrAddr_reg <= addrLow;
			end
			if (addrValid & ~hwrite) begin
				hrdata <= readMux;
			end
		end
	end

	// Register file update
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			aOperandLeg_reg <= `SAL_WORD_RST;
			bOperandLeg_reg <= `SAL_WORD_RST;
			ctrl_reg <= `SAL_CTRL_RST;
		end else begin
			aOperandLeg_reg <= aOperandLeg_next;
			bOperandLeg_reg <= bOperandLeg_next;
			ctrl_reg <= ctrl_next;
		end
	end

	// External data pins cross in through two flops
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			busSync1_reg <= `SAL_WORD_RST;
			busSync2_reg <= `SAL_WORD_RST;
		end else begin
			busSync1_reg <= busDataIn;
			busSync2_reg <= busSync1_reg;
		end
	end

	// Downstream capture one edge after operands settle
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			aluResult <= `SAL_WORD_RST;
			selectorOut <= `SAL_WORD_RST;
			lowByteEqual <= 1'b0;
			highByteEqual <= 1'b0;
			carryOut_reg <= 1'b0;
		end else begin
			aluResult <= aluOut;
			selectorOut <= selected;
			lowByteEqual <= sliceEq[0] & sliceEq[1];
			highByteEqual <= sliceEq[2] & sliceEq[3];
			carryOut_reg <= groupCout;
		end
	end
endmodule // sal_top
`default_nettype wire

// *** verification/sal_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
// Port-level watch on the datapath and its bus
module sal_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic [15:0] busDataIn,
	input wire logic [15:0] aluResult,
	input wire logic [15:0] selectorOut,
	input wire logic lowByteEqual,
	input wire logic highByteEqual
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// A write needs three edges to reach the outputs
	wire logic tk = hsel & htrans[1] & hready;
	wire logic rdTk = tk & !hwrite;
	sequence quiet;
		!(tk && hwrite) [*4];
	endsequence
	chk_low_equal: assert property (lowByteEqual == &aluResult[7:0])
		else $error("low byte equal wrong");
	chk_high_equal: assert property (highByteEqual == &aluResult[15:8])
		else $error("high byte equal wrong");
	chk_result_hold: assert property (quiet |=> $stable(aluResult))
		else $error("result moved");
	chk_sel_source: assert property (selectorOut == aluResult ||
		selectorOut == $past(busDataIn, 3)) else $error("selector source");
	chk_stat_view: assert property (quiet ##0 (rdTk && haddr[7:0] == 8'h0c) |=>
		hrdata[17:0] == {highByteEqual, lowByteEqual, aluResult}) else $error("stat");
	chk_rdata_hold: assert property (!rdTk |=> $stable(hrdata))
		else $error("read data moved");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready");
	chk_unmapped_zero: assert property (rdTk && haddr[7:0] == 8'h14 |=> !hrdata)
		else $error("unmapped read");
endmodule // sal_chk
bind sal_top sal_chk u_chk (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .hrdata, .busDataIn, .aluResult, .selectorOut, .lowByteEqual,
	.highByteEqual);
`default_nettype wire

// *** verification/sal_cs_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Control store side: builds the control word
module sal_cs_model (
	input wire logic [3:0] fn,
	input wire logic mode,
	input wire logic cin,
	input wire logic auxReq,
	input wire logic savedC,
	input wire logic rsel,
	output logic [31:0] ctrlWord
);
	// Function selects and requests leave active low
	assign ctrlWord = {23'h0, rsel, ~savedC, ~auxReq, cin, mode, ~fn};
endmodule // sal_cs_model
`default_nettype wire

// *** verification/sixteen_bit_alu_slice_datapath_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_alu_slice_datapath_tb;
	logic mclk, rst, hsel, hwrite, hreadyout, hresp, lowByteEqual, highByteEqual;
	logic [31:0] haddr, hwdata, hrdata, ctrlWord, rd;
	logic [1:0] htrans;
	logic [15:0] busDataIn, aluResult, selectorOut, a, b;
	logic [3:0] fn;
	logic mode, cin, auxReq, savedC, rsel;
	logic [16:0] e;
	int errors = 0, samples_checked = 0, cycles = 0;
	sal_top DUT (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .busDataIn, .aluResult,
		.selectorOut, .lowByteEqual, .highByteEqual);
	sal_cs_model CS (.fn, .mode, .cin, .auxReq, .savedC, .rsel, .ctrlWord);
	initial begin
		mclk = 0;
		forever #12.5 mclk = ~mclk;
	end
	// Expected word and carry
	function automatic logic [16:0] calc(logic [15:0] x, y, logic [3:0] s, logic m, c);
		logic [15:0] t, u;
		t = x | (y & {16{s[0]}}) | (~y & {16{s[1]}});
		u = (x & ~y & {16{s[2]}}) | (x & y & {16{s[3]}});
		calc = m ? {1'b0, ~(t ^ u)} : {1'b0, t} + {1'b0, u} + 17'(c);
	endfunction
	task cmp(logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One single transfer; hold each phase until hready
	task xfer(logic w, logic [7:0] ad, logic [31:0] d);
		@(posedge mclk);
		{hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 24'h0, ad};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task give_verdict;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard, well above the run length
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			errors++;
			give_verdict;
		end
	end
	initial begin
		{rst, hsel, hwrite, htrans, haddr, hwdata, busDataIn} = {1'b1, 84'h0};
		rd = $urandom(32'hfd1b8bd5);
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		xfer(0, 8'h08, 0);
		cmp(rd, 32'h0cf);
		xfer(0, 8'h14, 0);
		// Every function in both modes, corners at 12 and 18
		for (int i = 0; i < 64; i++) begin
			{a, b, cin, auxReq, savedC, rsel} = 36'({$urandom, $urandom});
			{fn, mode} = 5'(i);
			if (i == 12)
				{b, cin, auxReq, savedC} = {a, 3'b111};
			if (i == 18)
				{a, b, cin, auxReq, savedC} = {16'hffff, 16'h0, 3'b100};
			busDataIn <= 16'($urandom);
			xfer(1, 8'h00, {16'h0, a});
			xfer(1, 8'h04, {16'h0, b});
			xfer(1, 8'h08, ctrlWord);
			@(posedge mclk);
			#1;
			e = calc(a, b, fn, mode, cin ^ (auxReq & savedC));
			cmp(aluResult, e[15:0]);
			cmp({lowByteEqual, highByteEqual}, {&e[7:0], &e[15:8]});
			xfer(0, 8'h0c, 0);
			// Carry out only means something in arithmetic mode
			rd = rd & {13'h0, !mode, 18'h3ffff};
			cmp(rd, {13'h0, e[16] & !mode, &e[15:8], &e[7:0], e[15:0]});
			xfer(0, 8'h10, 0);
			cmp(rd, {16'h0, rsel ? e[15:0] : busDataIn});
		end
		xfer(0, 8'h00, 0);
		cmp(rd, {16'h0, a});
		give_verdict;
	end
endmodule // sixteen_bit_alu_slice_datapath_tb
`default_nettype wire
